/* File: logic/dpm_host.sv */
`timescale 1ns/1ps
// Summary of operation
// - Token select low steers the access to the token latches.
// - A token is requested by writing 0 to it.
// - Master plus slaves widen the memory with no extra logic.
// - Read data is driven only while output enable is low; the device model drives the inverted memory word while it is high.
// - Chip enable stays high while token select is low.
module dpm_host (
	input wire logic mclk,
	input wire logic reset,
	input wire logic clkEn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	output logic [dpm_pkg::ADDR_W-1:0] portAddress,
	output logic [dpm_pkg::DATA_W-1:0] portDataOut,
	output logic portDataOeN,
	input wire logic [dpm_pkg::DATA_W-1:0] portDataIn,
	output logic ceN,
	output logic semN,
	output logic rwN,
	output logic oeN,
	input wire logic busyN,
	input wire logic intN,
	output logic roleMaster
);
	import dpm_pkg::*;

	typedef enum logic [1:0] {CS_IDLE, CS_ISSUE, CS_WAIT} dpm_cs_t;

	dpm_acc_if acc();

	logic busPend;
	logic busWrite;
	logic busHit;
	logic [7:0] busAddr;
	logic wrEn;
	logic rdEn;
	logic sideRight;
	logic [12:0] cmdAddr;
	logic [8:0] cmdData;
	logic [8:0] lastRead;
	logic doneFlag;
	logic contendFlag;
	logic tokenOwned;
	logic mailboxPend;
	dpm_cs_t cstate;
	dpm_op_t curOp;
	logic [2:0] stepIdx;
	logic startReq;
	logic stepWrite;
	logic stepToken;
	logic [12:0] stepAddr;
	logic [8:0] stepData;
	logic lastStep;

	function automatic logic readsToken(input dpm_op_t op);
		readsToken = (op == OP_TOK_REQ) || (op == OP_TOK_READ);
	endfunction

	function automatic logic [12:0] tokenAddr(input logic [2:0] idx);
		tokenAddr = {10'h000, idx};
	endfunction

	dpm_pin_seq uSeq (
		.mclk(mclk),
		.reset(reset),
		.clkEn(clkEn),
		.acc(acc),
		.portAddress(portAddress),
		.portDataOut(portDataOut),
		.portDataOeN(portDataOeN),
		.portDataIn(portDataIn),
		.ceN(ceN),
		.semN(semN),
		.rwN(rwN),
		.oeN(oeN),
		.busyN(busyN)
	);

	// Bus slave: one wait state, so reads see writes of the cycle before
	always_ff @(posedge mclk) begin
		if (reset) begin
			busPend <= 1'b0;
			busWrite <= 1'b0;
			busHit <= 1'b0;
			busAddr <= 8'h00;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else if (clkEn) begin
			if (busPend) begin
				busPend <= 1'b0;
				hreadyout <= 1'b1;
			end else if (hsel && htrans[1] && hready) begin
				busPend <= 1'b1;
				busWrite <= hwrite;
				busHit <= (haddr[31:8] == 24'h000000) && (haddr[1:0] == 2'h0);
				busAddr <= haddr[7:0];
				hreadyout <= 1'b0;
			end
		end
	end

	assign wrEn = busPend && busWrite && busHit;
	assign rdEn = busPend && !busWrite;
	assign startReq = wrEn && (busAddr == REG_CTRL) && hwdata[CTRL_START_BIT]
		&& (cstate == CS_IDLE);

	always_ff @(posedge mclk) begin
		if (reset) begin
			hrdata <= 32'h00000000;
		end else if (clkEn && rdEn) begin
			if (!busHit) begin
				hrdata <= 32'h00000000;
			end else begin
				case (busAddr)
					REG_CTRL: begin
						hrdata <= {26'h0000000, sideRight, roleMaster, 1'b0, curOp};
					end
					REG_ADDR: begin
						hrdata <= {19'h00000, cmdAddr};
					end
					REG_WDATA: begin
						hrdata <= {23'h000000, cmdData};
					end
					REG_RDATA: begin
						hrdata <= {23'h000000, lastRead};
					end
					REG_STATUS: begin
						hrdata <= {27'h0000000, contendFlag, mailboxPend, tokenOwned,
							doneFlag, cstate != CS_IDLE};
					end
					default: begin
						hrdata <= 32'h00000000;
					end
				endcase
			end
		end
	end

	// Configuration and command words
	always_ff @(posedge mclk) begin
		if (reset) begin
			roleMaster <= CTRL_ROLE_RESET;
			sideRight <= CTRL_SIDE_RESET;
			cmdAddr <= 13'h0000;
			cmdData <= 9'h000;
		end else if (clkEn && wrEn) begin
			case (busAddr)
				REG_CTRL: begin
					// Device strap; only the master role watches busy as input, a slave ignores it
					roleMaster <= hwdata[CTRL_ROLE_BIT];
					sideRight <= hwdata[CTRL_SIDE_BIT];
				end
				REG_ADDR: begin
					cmdAddr <= hwdata[12:0];
				end
				REG_WDATA: begin
					cmdData <= hwdata[8:0];
				end
				default: begin
				end
			endcase
		end
	end

	// Pin access wanted by the current step of the running command
	always_comb begin
		stepWrite = 1'b0;
		stepToken = 1'b0;
		stepAddr = cmdAddr;
		stepData = cmdData;
		lastStep = 1'b1;
		case (curOp)
			OP_READ: begin
				stepWrite = 1'b0;
			end
			OP_WRITE: begin
				stepWrite = 1'b1;
			end
			OP_TOK_REQ: begin
				// Write 0 then read back: 0 means owned, 1 means the far side holds it
				stepToken = 1'b1;
				stepAddr = tokenAddr(cmdAddr[2:0]);
				stepWrite = (stepIdx == 3'h0);
				stepData = TOKEN_TAKE;
				lastStep = (stepIdx != 3'h0);
			end
			OP_TOK_REL: begin
				stepToken = 1'b1;
				stepWrite = 1'b1;
				stepAddr = tokenAddr(cmdAddr[2:0]);
				stepData = TOKEN_FREE;
			end
			OP_TOK_READ: begin
				stepToken = 1'b1;
				stepAddr = tokenAddr(cmdAddr[2:0]);
			end
			OP_TOK_INIT: begin
				// Tokens are not cleared at power up; free all eight from this side
				stepToken = 1'b1;
				stepWrite = 1'b1;
				stepAddr = tokenAddr(stepIdx);
				stepData = TOKEN_FREE;
				lastStep = (stepIdx == 3'(TOKEN_CNT - 1));
			end
			OP_MB_SEND: begin
				stepWrite = 1'b1;
				stepAddr = sideRight ? MAILBOX_LEFT : MAILBOX_RIGHT;
			end
			OP_MB_TAKE: begin
				stepAddr = sideRight ? MAILBOX_RIGHT : MAILBOX_LEFT;
			end
			default: begin
			end
		endcase
	end

	// Command sequencer
	always_ff @(posedge mclk) begin
		if (reset) begin
			cstate <= CS_IDLE;
			curOp <= OP_READ;
			stepIdx <= 3'h0;
			acc.req <= 1'b0;
			acc.isWrite <= 1'b0;
			acc.isToken <= 1'b0;
			acc.watchBusy <= 1'b0;
			acc.addr <= 13'h0000;
			acc.wdata <= 9'h000;
			lastRead <= 9'h000;
			tokenOwned <= 1'b0;
		end else if (clkEn) begin
			acc.req <= 1'b0;
			case (cstate)
				CS_IDLE: begin
					if (startReq) begin
						curOp <= dpm_op_t'(hwdata[CTRL_OP_LSB +: 3]);
						stepIdx <= 3'h0;
						cstate <= CS_ISSUE;
					end
				end
				CS_ISSUE: begin
					acc.req <= 1'b1;
					acc.isWrite <= stepWrite;
					acc.isToken <= stepToken;
					acc.watchBusy <= roleMaster;
					acc.addr <= stepAddr;
					acc.wdata <= stepData;
					cstate <= CS_WAIT;
				end
				CS_WAIT: begin
					if (acc.done) begin
						if (!stepWrite) begin
							lastRead <= acc.rdata;
						end
						if (!stepWrite && readsToken(curOp)) begin
							tokenOwned <= ~acc.rdata[0];
						end
						if (lastStep) begin
							cstate <= CS_IDLE;
						end else begin
							stepIdx <= stepIdx + 3'h1;
							cstate <= CS_ISSUE;
						end
					end
				end
				default: begin
					cstate <= CS_IDLE;
				end
			endcase
		end
	end

	// Sticky done and contention flags: a new event wins over a write-one clear in the same cycle; mailbox pending follows intN
	always_ff @(posedge mclk) begin
		if (reset) begin
			doneFlag <= 1'b0;
			contendFlag <= 1'b0;
			mailboxPend <= 1'b0;
		end else if (clkEn) begin
			mailboxPend <= ~intN;
			if (cstate == CS_WAIT && acc.done && lastStep) begin
				doneFlag <= 1'b1;
			end else if (wrEn && busAddr == REG_STATUS && hwdata[STAT_DONE_BIT]) begin
				doneFlag <= 1'b0;
			end
			if (acc.busyHit) begin
				contendFlag <= 1'b1;
			end else if (wrEn && busAddr == REG_STATUS && hwdata[STAT_CONTEND_BIT]) begin
				contendFlag <= 1'b0;
			end
		end
	end
endmodule

/* File: common/dpm_pkg.sv */
package dpm_pkg;
	localparam int DATA_W = 9;
	localparam int ADDR_W = 13;
	localparam int TOKEN_CNT = 8;
	localparam int TOKEN_AW = 3;
	localparam logic [12:0] MAILBOX_LEFT = 13'h1ffe;
	localparam logic [12:0] MAILBOX_RIGHT = 13'h1fff;
	localparam logic [8:0] TOKEN_TAKE = 9'h000;
	localparam logic [8:0] TOKEN_FREE = 9'h001;

	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_ADDR = 8'h04;
	localparam logic [7:0] REG_WDATA = 8'h08;
	localparam logic [7:0] REG_RDATA = 8'h0c;
	localparam logic [7:0] REG_STATUS = 8'h10;

	localparam int CTRL_OP_LSB = 0;
	localparam int CTRL_START_BIT = 3;
	localparam int CTRL_ROLE_BIT = 4;
	localparam int CTRL_SIDE_BIT = 5;
	localparam logic CTRL_ROLE_RESET = 1'b1;
	localparam logic CTRL_SIDE_RESET = 1'b0;

	localparam int STAT_ACTIVE_BIT = 0;
	localparam int STAT_DONE_BIT = 1;
	localparam int STAT_OWNED_BIT = 2;
	localparam int STAT_MAILBOX_BIT = 3;
	localparam int STAT_CONTEND_BIT = 4;

	localparam int CLK_NS = 20;
	localparam int ACCESS_NS = 55;
	localparam int GAP_NS = 15;
	localparam logic [2:0] STROBE_CYC = 3'((ACCESS_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [2:0] GAP_CYC = 3'((GAP_NS + CLK_NS - 1) / CLK_NS);

	typedef enum logic [2:0] {
		OP_READ, OP_WRITE, OP_TOK_REQ, OP_TOK_REL,
		OP_TOK_READ, OP_TOK_INIT, OP_MB_SEND, OP_MB_TAKE
	} dpm_op_t;
endpackage

/* File: common/dpm_acc_if.sv */
`timescale 1ns/1ps
interface dpm_acc_if;
	logic req;
	logic isWrite;
	logic isToken;
	logic watchBusy;
	logic [12:0] addr;
	logic [8:0] wdata;
	logic [8:0] rdata;
	logic done;
	logic busyHit;
	modport ctl (output req, isWrite, isToken, watchBusy, addr, wdata,
		input rdata, done, busyHit);
	modport seq (input req, isWrite, isToken, watchBusy, addr, wdata,
		output rdata, done, busyHit);
endinterface

/* File: logic/dpm_pin_seq.sv */
`timescale 1ns/1ps
module dpm_pin_seq (
	input wire logic mclk,
	input wire logic reset,
	input wire logic clkEn,
	dpm_acc_if.seq acc,
	output logic [dpm_pkg::ADDR_W-1:0] portAddress,
	output logic [dpm_pkg::DATA_W-1:0] portDataOut,
	output logic portDataOeN,
	input wire logic [dpm_pkg::DATA_W-1:0] portDataIn,
	output logic ceN,
	output logic semN,
	output logic rwN,
	output logic oeN,
	input wire logic busyN
);
	import dpm_pkg::*;

	typedef enum logic [2:0] {SQ_IDLE, SQ_SELECT, SQ_STROBE, SQ_RELEASE, SQ_GAP} dpm_sq_t;
	dpm_sq_t state;
	logic [2:0] cnt;
	logic curWrite;
	logic curToken;
	logic curWatch;

	always_ff @(posedge mclk) begin
		if (reset) begin
			state <= SQ_IDLE;
			cnt <= 3'h0;
			curWrite <= 1'b0;
			curToken <= 1'b0;
			curWatch <= 1'b0;
			portAddress <= '0;
			portDataOut <= '0;
			portDataOeN <= 1'b1;
			ceN <= 1'b1;
			semN <= 1'b1;
			rwN <= 1'b1;
			oeN <= 1'b1;
			acc.rdata <= '0;
			acc.done <= 1'b0;
			acc.busyHit <= 1'b0;
		end else if (clkEn) begin
			acc.done <= 1'b0;
			acc.busyHit <= 1'b0;
			case (state)
				SQ_IDLE: begin
					if (acc.req) begin
						curWrite <= acc.isWrite;
						curToken <= acc.isToken;
						curWatch <= acc.watchBusy & ~acc.isToken;
						portAddress <= acc.addr;
						portDataOut <= acc.wdata;
						portDataOeN <= ~acc.isWrite;
						// Only one select low at a time
						ceN <= acc.isToken;
						semN <= ~acc.isToken;
						state <= SQ_SELECT;
					end
				end
				SQ_SELECT: begin
					// Contention: hold the strobe off until the busy flag clears
					if (curWatch && !busyN) begin
						acc.busyHit <= 1'b1;
					end else begin
						rwN <= ~curWrite;
						oeN <= curWrite;
						cnt <= STROBE_CYC - 3'h1;
						state <= SQ_STROBE;
					end
				end
				SQ_STROBE: begin
					if (cnt == 3'h0) begin
						if (!curWrite) begin
							acc.rdata <= portDataIn;
						end
						// Rising write strobe ends the write
						rwN <= 1'b1;
						oeN <= 1'b1;
						state <= SQ_RELEASE;
					end else begin
						cnt <= cnt - 3'h1;
					end
				end
				SQ_RELEASE: begin
					ceN <= 1'b1;
					semN <= 1'b1;
					portDataOeN <= 1'b1;
					acc.done <= 1'b1;
					cnt <= GAP_CYC - 3'h1;
					state <= SQ_GAP;
				end
				SQ_GAP: begin
					// Selects stay off before the next access, so a token read sees the write
					if (cnt == 3'h0) begin
						state <= SQ_IDLE;
					end else begin
						cnt <= cnt - 3'h1;
					end
				end
				default: begin
					state <= SQ_IDLE;
				end
			endcase
		end
	end
endmodule

/* File: dv/dpm_dev_model.sv */
`timescale 1ns/1ps
module dpm_dev_model (
	input wire logic [12:0] portAddress,
	input wire logic [8:0] portDataOut,
	output logic [8:0] portDataIn,
	input wire logic ceN,
	input wire logic semN,
	input wire logic rwN,
	input wire logic oeN,
	output logic busyN,
	output logic intN,
	input wire logic side,
	input wire logic farPoke,
	input wire logic contend,
	input wire logic [7:0] farTok
);
	logic [8:0] mem [0:8191];
	logic [7:0] mine = 8'h00;
	logic mbLow = 1'b0;
	logic [8:0] tokHold;
	logic [2:0] ta;
	assign intN = ~mbLow;
	assign ta = portAddress[2:0];
	assign busyN = ~(contend & ~ceN);
	always @(negedge oeN) tokHold = {9{~mine[ta]}};
	always @* begin
		if (!oeN && !ceN) portDataIn = mem[portAddress];
		else if (!oeN && !semN) portDataIn = tokHold;
		else portDataIn = ~mem[portAddress]; // Released lines show no stale value
	end
	// Writes land when the write strobe rises
	always @(posedge rwN) begin
		if (!ceN) mem[portAddress] <= portDataOut;
		else if (!semN && !portDataOut[0] && !farTok[ta]) mine[ta] <= 1'b1;
		else if (!semN && portDataOut[0]) mine[ta] <= 1'b0;
	end
	always @(posedge farPoke or negedge oeN) begin
		if (farPoke) mbLow <= 1'b1;
		else if (!ceN && portAddress == (side ? 13'h1fff : 13'h1ffe)) mbLow <= 1'b0;
	end
endmodule

/* File: dv/dpm_host_assertions.sv */
`timescale 1ns/1ps
module dpm_host_assertions (
	input wire logic mclk,
	input wire logic reset,
	input wire logic clkEn,
	input wire logic hsel,
	input wire logic [1:0] htrans,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic [dpm_pkg::ADDR_W-1:0] portAddress,
	input wire logic [dpm_pkg::DATA_W-1:0] portDataOut,
	input wire logic portDataOeN,
	input wire logic ceN,
	input wire logic semN,
	input wire logic rwN,
	input wire logic oeN
);
	default clocking @(posedge mclk); endclocking
	default disable iff (reset);
	sel_excl_a: assert property (ceN || semN) else $error("both selects low");
	wr_strobe_a: assert property ($fell(rwN) |-> (!rwN)[*3] ##1 rwN)
		else $error("write strobe length");
	rd_strobe_a: assert property ($fell(oeN) |-> (!oeN)[*3] ##1 oeN)
		else $error("read strobe length");
	wr_drive_a: assert property (!rwN |-> !portDataOeN && oeN) else $error("write undriven");
	rd_float_a: assert property (!oeN |-> portDataOeN) else $error("read contention");
	tok_bit_a: assert property (!semN && !rwN |-> portDataOut[8:1] == 8'h00)
		else $error("token data");
	strobe_sel_a: assert property (!rwN || !oeN |-> !ceN || !semN)
		else $error("strobe unselected");
	addr_hold_a: assert property (!ceN && !$past(ceN) |-> $stable(portAddress))
		else $error("address moved");
	bus_ready_a: assert property (hsel && htrans[1] && hready && clkEn |=> !hreadyout ##1 hreadyout)
		else $error("ready timing");
	resp_ok_a: assert property (hresp == 1'b0) else $error("bad response");
	freeze_hold_a: assert property (!clkEn |=> $stable({portAddress, ceN, semN, rwN, oeN}))
		else $error("state moved while frozen");
	cover property ($fell(rwN) && !semN);
	cover property ($fell(oeN) && !semN);
	cover property ($fell(rwN) && !ceN);
endmodule
bind dpm_host dpm_host_assertions chk (.mclk(mclk), .reset(reset), .clkEn(clkEn), .hsel(hsel),
	.htrans(htrans), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
	.portAddress(portAddress), .portDataOut(portDataOut), .portDataOeN(portDataOeN),
	.ceN(ceN), .semN(semN), .rwN(rwN), .oeN(oeN));

/* File: dv/dpm_host_tb.sv */
`timescale 1ns/1ps
module dpm_host_tb;
	import dpm_pkg::*;
	logic mclk = 1'b0;
	logic reset = 1'b1;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic clkEn = 1'b1;
	logic role = 1'b1;
	logic roleMaster;
	logic hreadyout, hresp, portDataOeN, ceN, semN, rwN, oeN, busyN, intN;
	logic [31:0] hrdata, e, m;
	logic [12:0] portAddress;
	logic [8:0] portDataOut, portDataIn;
	logic farPoke = 1'b0;
	logic contend = 1'b0;
	logic side = 1'b0;
	logic rdPh = 1'b0;
	logic [7:0] farTok = 8'h00;
	logic [31:0] rng = 32'd63979;
	logic [31:0] expQ[$], mskQ[$];
	int error_cnt = 0;
	int checked = 0;
	int cyc = 0;
	always #10 mclk = ~mclk;
	dpm_host dut (.mclk(mclk), .reset(reset), .clkEn(clkEn), .hsel(1'b1), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .portAddress(portAddress),
		.portDataOut(portDataOut), .portDataOeN(portDataOeN), .portDataIn(portDataIn),
		.ceN(ceN), .semN(semN), .rwN(rwN), .oeN(oeN), .busyN(busyN), .intN(intN),
		.roleMaster(roleMaster));
	dpm_dev_model dev (.portAddress(portAddress), .portDataOut(portDataOut),
		.portDataIn(portDataIn), .ceN(ceN), .semN(semN), .rwN(rwN), .oeN(oeN), .busyN(busyN),
		.intN(intN), .side(side), .farPoke(farPoke), .contend(contend), .farTok(farTok));
	function automatic logic [31:0] rnd();
		rng ^= rng << 13;
		rng ^= rng >> 17;
		rng ^= rng << 5;
		return rng;
	endfunction
	task pin_chk(input logic got, input logic exp);
		checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] %0t exp %h got %h", $time, exp, got);
		end
	endtask
	task stop_test();
		$display("errors %0d checks %0d", error_cnt, checked);
		if (error_cnt == 0 && checked > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 20000) begin
			error_cnt++;
			stop_test();
		end
	end
	// Read results are compared against the oldest note
	always @(posedge mclk) begin
		if (rdPh && hreadyout) begin
			e = expQ.pop_front();
			m = mskQ.pop_front();
			if (m != 32'h0) begin
				checked++;
				if ((hrdata & m) !== e) begin
					error_cnt++;
					$display("[ERR] %0t exp %h got %h", $time, e, hrdata & m);
				end
			end
		end
		if (hreadyout) rdPh <= htrans[1] & ~hwrite;
	end
	task xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
		@(posedge mclk);
		haddr <= {24'h0, a};
		hwrite <= w;
		htrans <= 2'b10;
		do @(posedge mclk); while (hreadyout !== 1'b1);
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge mclk); while (hreadyout !== 1'b1);
	endtask
	task rd(input logic [7:0] a, input logic [31:0] ex, input logic [31:0] mk);
		expQ.push_back(ex);
		mskQ.push_back(mk);
		xfer(a, 1'b0, 32'h0);
	endtask
	task op(input logic [2:0] o, input logic [12:0] a, input logic [8:0] d);
		xfer(REG_STATUS, 1'b1, 32'h12);
		xfer(REG_ADDR, 1'b1, {19'h0, a});
		xfer(REG_WDATA, 1'b1, {23'h0, d});
		xfer(REG_CTRL, 1'b1, {26'h0, side, role, 1'b1, o});
		// Freeze the block while the command waits to reach the pins
		clkEn <= 1'b0;
		repeat (1 + rnd() % 3) @(posedge mclk);
		clkEn <= 1'b1;
		do rd(REG_STATUS, 32'h0, 32'h0); while (hrdata[STAT_DONE_BIT] !== 1'b1);
	endtask
	initial begin
		logic [12:0] a;
		logic [8:0] d;
		repeat (8) @(posedge mclk);
		reset <= 1'b0;
		rd(REG_CTRL, 32'h10, 32'hffffffff);
		pin_chk(roleMaster, CTRL_ROLE_RESET);
		rd(REG_STATUS, 32'h0, 32'h1f);
		rd(8'h20, 32'h0, 32'hffffffff);
		for (int i = 0; i < 4; i++) begin
			a = 13'(rnd()) & 13'h0fff;
			d = 9'(rnd());
			side <= i[0];
			op(OP_WRITE, a, d);
			op(OP_READ, a, 9'h0);
			rd(REG_RDATA, {23'h0, d}, 32'h1ff);
		end
		side <= 1'b0;
		op(OP_TOK_INIT, 13'h0, 9'h0);
		op(OP_TOK_REQ, 13'h1ab3, 9'h0);
		rd(REG_STATUS, 32'h4, 32'h4);
		farTok <= 8'h40;
		op(OP_TOK_REQ, 13'h0006, 9'h0);
		rd(REG_STATUS, 32'h0, 32'h4);
		op(OP_TOK_REL, 13'h0003, 9'h0);
		op(OP_TOK_READ, 13'h0003, 9'h0);
		rd(REG_RDATA, 32'h1ff, 32'h1ff);
		for (int s = 0; s < 2; s++) begin
			side <= s[0];
			farPoke <= 1'b1;
			@(posedge mclk) farPoke <= 1'b0;
			rd(REG_STATUS, 32'h8, 32'h8);
			op(OP_MB_TAKE, 13'h0, 9'h0);
			rd(REG_STATUS, 32'h0, 32'h8);
			op(OP_MB_SEND, 13'h0, 9'h0a5 + 9'(s));
			op(OP_READ, s ? 13'h1ffe : 13'h1fff, 9'h0);
			rd(REG_RDATA, 32'h0a5 + s, 32'h1ff);
		end
		contend <= 1'b1;
		fork
			begin
				wait (!ceN);
				repeat (4) @(posedge mclk);
				contend <= 1'b0;
			end
		join_none
		op(OP_READ, 13'h0100, 9'h0);
		rd(REG_STATUS, 32'h10, 32'h10);
		// Slave role: busy is not watched, so no stall and no contention
		role <= 1'b0;
		contend <= 1'b1;
		op(OP_READ, 13'h0100, 9'h0);
		rd(REG_STATUS, 32'h0, 32'h10);
		pin_chk(roleMaster, 1'b0);
		stop_test();
	end
endmodule
